// ### design/base_clock_switch.sv
// Glitch-free selector between crystal and VCO clock with divide by two
`timescale 1ns/100ps
module base_clock_switch (
	input wire logic ref_clk_in, // System clock
	input wire logic rst_b_in, // Asynchronous reset, active low
	input wire logic crystal_clock_in, // Sampled crystal clock level
	input wire logic vco_clock_in, // Sampled VCO clock level
	input wire logic vco_run_in, // VCO is running
	input wire logic sel_vco_in, // Requested source, 1 = VCO
	output logic base_clock_out, // Selected source divided by two
	output logic busy_out // Transition in progress
);
	import clk_ctl_pkg::*;

	sw_st_t st_q;
	sw_st_t st_d;
	logic xtal_rise;
	logic vco_rise;
	logic src_rise;
	logic vco_done;

	always_comb begin
		st_d = st_q;
		xtal_rise = crystal_clock_in & ~st_q.xtal_prev;
		vco_rise = vco_clock_in & ~st_q.vco_prev;
		src_rise = st_q.sel ? vco_rise : xtal_rise;
		// A stopped VCO cannot deliver edges, so it does not hold up the change
		vco_done = (st_q.vco_cnt == SWITCH_EDGES) | ~vco_run_in;
		st_d.xtal_prev = crystal_clock_in;
		st_d.vco_prev = vco_clock_in;
		unique case (st_q.mode)
			SW_RUN: begin
				if (sel_vco_in != st_q.sel) begin
					st_d.mode = SW_HOLD;
					st_d.target = sel_vco_in;
					st_d.xtal_cnt = 2'd0;
					st_d.vco_cnt = 2'd0;
				end else if (src_rise) begin
					st_d.out = ~st_q.out; // RULE17
				end
			end
			SW_HOLD: begin
				// Output stays frozen while edges of both sources are counted
				if (xtal_rise && st_q.xtal_cnt != SWITCH_EDGES) begin
					st_d.xtal_cnt = st_q.xtal_cnt + 2'd1; // RULE16
				end
				if (vco_rise && st_q.vco_cnt != SWITCH_EDGES) begin
					st_d.vco_cnt = st_q.vco_cnt + 2'd1; // RULE16
				end
				if (st_q.xtal_cnt == SWITCH_EDGES && vco_done) begin
					st_d.sel = st_q.target; // RULE16
					st_d.mode = SW_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign base_clock_out = st_q.out;
	assign busy_out = (st_q.mode == SW_HOLD);
endmodule

// ### design/clk_ctl_pkg.sv
// Shared constants and types for the loop mode control and base clock selector
package clk_ctl_pkg;

	// ==============================
	// Register indices and byte addresses
	localparam logic [7:0] LOOP_CTRL_IDX = 8'h1c;
	localparam logic [7:0] BW_CTRL_IDX = 8'h1d;
	localparam logic [7:0] MULT_PROG_IDX = 8'h1e;
	localparam logic [9:0] LOOP_CTRL_ADDR = {LOOP_CTRL_IDX, 2'b00};
	localparam logic [9:0] BW_CTRL_ADDR = {BW_CTRL_IDX, 2'b00};
	localparam logic [9:0] MULT_PROG_ADDR = {MULT_PROG_IDX, 2'b00};

	// ==============================
	// Field positions
	localparam int IRQ_EN_BIT = 7;
	localparam int FLAG_BIT = 6;
	localparam int LOOP_ON_BIT = 5;
	localparam int SRC_SEL_BIT = 4;
	localparam int AUTO_BIT = 7;
	localparam int LOCK_BIT = 6;
	localparam int ACQ_BIT = 5;
	localparam int FB_MSB = 7;
	localparam int FB_LSB = 4;
	localparam int RNG_MSB = 3;
	localparam int RNG_LSB = 0;

	// ==============================
	// Reset values and fixed read patterns
	localparam logic LOOP_ON_RESET = 1'b1;
	localparam logic [7:0] MULT_PROG_RESET = 8'h11;
	localparam logic [3:0] CTRL_LOW_ONES = 4'hf;
	localparam logic [3:0] FB_ONE = 4'h1;
	localparam logic [3:0] RNG_OFF = 4'h0;

	// ==============================
	// Clock switch timing
	localparam logic [1:0] SWITCH_EDGES = 2'd3;

	// ==============================
	// Types
	typedef struct packed {
		logic inner;
		logic outer;
	} tol_win_t;

	typedef enum logic {SW_RUN, SW_HOLD} sw_mode_t;

	typedef struct packed {
		sw_mode_t mode;
		logic sel;
		logic target;
		logic xtal_prev;
		logic vco_prev;
		logic [1:0] xtal_cnt;
		logic [1:0] vco_cnt;
		logic out;
	} sw_st_t;

	typedef struct packed {
		logic held;
	} win_st_t;

	typedef struct packed {
		logic irq_en;
		logic flag;
		logic loop_on;
		logic src_sel;
		logic auto_bw;
		logic acq_man;
		logic [7:0] mult_prog;
		logic lock_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic loop_en;
		logic tracking;
		logic [3:0] fb_mult;
		logic [3:0] rng_mult;
	} ctrl_st_t;

endpackage

// ### design/pll_mode_and_base_clock_select.sv
// Loop filter mode, lock indication, multiplier programming and base clock control
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps

// Notes on behaviour
// RULE1: Acquisition mode reads as acquisition-mode bit cleared.
// RULE2: Filter tracks whenever not acquiring or the bit is set.
// RULE3: Automatic mode lets the lock detector pick the filter mode.
// RULE4: Automatic mode makes the acquisition-mode bit read-only, showing filter mode.
// RULE5: Automatic tracking sets inside tracking tolerance, clears outside untracking tolerance.
// RULE6: Lock bit sets inside lock tolerance, clears outside unlock tolerance.
// RULE7: With interrupt enable set, each lock toggle requests an interrupt.
// RULE8: Manual mode: software writes the acquisition-mode bit to pick filter mode.
// RULE9: Software clears the acquisition-mode bit before turning the loop on manually.
// RULE10: Software waits acquisition time after loop-on before entering tracking.
// RULE11: Software waits acquisition-to-lock time before selecting the VCO clock.
// RULE12: Manual mode disables the lock indicator and all interrupts.
// RULE13: Programming register: feedback multiplier high nibble, range multiplier low nibble.
// RULE14: Feedback multiplier zero acts as one.
// RULE15: Range multiplier zero disables loop and forces the crystal clock.
// RULE16: Source change waits three edges of each clock, output held.
// RULE17: Selected clock divided by two gives the base clock.
// RULE18: VCO clock cannot be selected while the loop is off.
// RULE19: Loop cannot be switched off while the VCO clock is selected.
// RULE20: Loop-on change and source change need separate writes.
// RULE21: Software selects VCO only after lock; lost lock means disturbance.
// RULE22: Lock-change flag sets on each toggle, clears on control register read.
// RULE23: Manual mode reads flag and lock as zero, forces interrupt enable low.
// RULE24: Programming register ignores writes while the loop is on.
// RULE25: A refused interlock bit keeps its value; other fields still update.
module pll_mode_and_base_clock_select (
	input wire logic ref_clk_in, // System clock, 10 MHz
	input wire logic rst_b_in, // Asynchronous reset, active low
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB direction, 1 = write
	input wire logic [9:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error on unmapped address
	input wire logic crystal_clock_in, // Sampled crystal clock
	input wire logic vco_clock_in, // Sampled VCO clock
	input wire clk_ctl_pkg::tol_win_t track_window_in, // Tracking/untracking tolerance hits
	input wire clk_ctl_pkg::tol_win_t lock_window_in, // Lock/unlock tolerance hits
	output logic base_clock_out, // Base clock to the system integration module
	output logic lock_irq_out, // Lock change interrupt request
	output logic loop_enable_out, // Loop and VCO enabled
	output logic tracking_mode_out, // Filter mode, 1 = tracking
	output logic [3:0] feedback_mult_out, // Effective feedback multiplier
	output logic [3:0] range_mult_out // Range multiplier
);
	import clk_ctl_pkg::*;

	// ==============================
	// Address decode
	function automatic logic reg_hit(input logic [9:0] addr, input logic [9:0] base);
		reg_hit = (addr == base);
	endfunction

	function automatic logic addr_mapped(input logic [9:0] addr);
		addr_mapped = reg_hit(addr, LOOP_CTRL_ADDR) | reg_hit(addr, BW_CTRL_ADDR)
			| reg_hit(addr, MULT_PROG_ADDR);
	endfunction

	// ==============================
	// State
	ctrl_st_t st_q;
	ctrl_st_t st_d;
	logic track_held;
	logic lock_held;
	logic loop_live;
	logic detect_en;
	logic setup;
	logic done_wr;
	logic done_rd;
	logic lock_toggle;
	logic acq_eff;
	logic loop_on_new;
	logic [7:0] ctrl_rd;
	logic [7:0] bw_rd;
	logic [7:0] prog_rd;
	logic [7:0] rd_byte;

	assign loop_live = st_q.loop_on & (st_q.mult_prog[RNG_MSB:RNG_LSB] != RNG_OFF); // RULE15
	assign detect_en = st_q.auto_bw & loop_live; // RULE12

	// ==============================
	// Lock detector hysteresis
	tolerance_window_latch track_latch (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.enable_in(detect_en),
		.window_in(track_window_in),
		.held_out(track_held) // RULE5
	);

	tolerance_window_latch lock_latch (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.enable_in(detect_en),
		.window_in(lock_window_in),
		.held_out(lock_held) // RULE6
	);

	// ==============================
	// Base clock selector
	base_clock_switch clk_switch (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.crystal_clock_in(crystal_clock_in),
		.vco_clock_in(vco_clock_in),
		.vco_run_in(loop_live),
		.sel_vco_in(st_q.src_sel & loop_live), // RULE15
		.base_clock_out(base_clock_out),
		.busy_out()
	);

	// ==============================
	// Next state
	always_comb begin
		st_d = st_q;
		setup = psel_in & ~penable_in;
		done_wr = psel_in & penable_in & st_q.pready & pwrite_in;
		done_rd = psel_in & penable_in & st_q.pready & ~pwrite_in;
		loop_on_new = st_q.loop_on;

		// Filter mode: automatic follows the detector, manual follows software
		acq_eff = st_q.auto_bw ? track_held : st_q.acq_man; // RULE3 RULE4 RULE8

		ctrl_rd = {st_q.irq_en & st_q.auto_bw, st_q.flag & st_q.auto_bw, // RULE23
			st_q.loop_on, st_q.src_sel, CTRL_LOW_ONES};
		bw_rd = {st_q.auto_bw, lock_held & st_q.auto_bw, acq_eff, 5'h00}; // RULE1 RULE4 RULE23
		prog_rd = st_q.mult_prog;
		if (reg_hit(paddr_in, LOOP_CTRL_ADDR)) begin
			rd_byte = ctrl_rd;
		end else if (reg_hit(paddr_in, BW_CTRL_ADDR)) begin
			rd_byte = bw_rd;
		end else if (reg_hit(paddr_in, MULT_PROG_ADDR)) begin
			rd_byte = prog_rd;
		end else begin
			rd_byte = 8'h00;
		end

		// APB: read data and error captured in setup, ready in the access cycle
		st_d.pready = setup;
		if (setup) begin
			st_d.pslverr = ~addr_mapped(paddr_in);
			st_d.prdata = pwrite_in ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end else begin
			st_d.pslverr = 1'b0;
		end

		// Lock change: only a flag value software actually saw is cleared, and
		// a toggle in the clearing cycle wins over the clear
		st_d.lock_prev = lock_held;
		lock_toggle = st_q.auto_bw & (lock_held != st_q.lock_prev); // RULE22
		if (lock_toggle) begin
			st_d.flag = 1'b1; // RULE22
		end else if (done_rd && reg_hit(paddr_in, LOOP_CTRL_ADDR)
			&& st_q.prdata[FLAG_BIT]) begin
			st_d.flag = 1'b0; // RULE22
		end

		// Control register write with the loop/source interlocks
		if (done_wr && reg_hit(paddr_in, LOOP_CTRL_ADDR)) begin
			if (st_q.auto_bw) begin
				st_d.irq_en = pwdata_in[IRQ_EN_BIT];
			end
			loop_on_new = st_q.src_sel | pwdata_in[LOOP_ON_BIT]; // RULE19 RULE25
			st_d.loop_on = loop_on_new;
			if (loop_on_new != st_q.loop_on) begin
				st_d.src_sel = st_q.src_sel; // RULE20 RULE25
			end else if (!st_q.loop_on) begin
				st_d.src_sel = 1'b0; // RULE18
			end else begin
				st_d.src_sel = pwdata_in[SRC_SEL_BIT];
			end
		end

		// Bandwidth register: manual value kept aside while automatic
		if (done_wr && reg_hit(paddr_in, BW_CTRL_ADDR)) begin
			st_d.auto_bw = pwdata_in[AUTO_BIT];
			if (!st_q.auto_bw) begin
				st_d.acq_man = pwdata_in[ACQ_BIT]; // RULE8
			end
		end

		// Programming register is frozen while the loop runs
		if (done_wr && reg_hit(paddr_in, MULT_PROG_ADDR) && !st_q.loop_on) begin
			st_d.mult_prog = pwdata_in[7:0]; // RULE13 RULE24
		end

		// Forced values
		if (!st_d.auto_bw) begin
			st_d.irq_en = 1'b0; // RULE12 RULE23
			st_d.flag = 1'b0; // RULE23
		end
		if (!st_d.loop_on || st_d.mult_prog[RNG_MSB:RNG_LSB] == RNG_OFF) begin
			st_d.src_sel = 1'b0; // RULE15 RULE18
		end

		// Outputs, registered from the next state
		st_d.irq = st_d.irq_en & st_d.flag & st_d.auto_bw; // RULE7 RULE12
		st_d.loop_en = st_d.loop_on & (st_d.mult_prog[RNG_MSB:RNG_LSB] != RNG_OFF); // RULE15
		st_d.tracking = st_d.auto_bw ? track_held : st_d.acq_man; // RULE2
		st_d.fb_mult = (st_d.mult_prog[FB_MSB:FB_LSB] == 4'h0) ? FB_ONE
			: st_d.mult_prog[FB_MSB:FB_LSB]; // RULE14
		st_d.rng_mult = st_d.mult_prog[RNG_MSB:RNG_LSB]; // RULE13
	end

	// ==============================
	// State register
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
			st_q.loop_on <= LOOP_ON_RESET;
			st_q.mult_prog <= MULT_PROG_RESET;
			st_q.loop_en <= LOOP_ON_RESET;
			st_q.fb_mult <= MULT_PROG_RESET[FB_MSB:FB_LSB];
			st_q.rng_mult <= MULT_PROG_RESET[RNG_MSB:RNG_LSB];
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata_out = st_q.prdata;
	assign pready_out = st_q.pready;
	assign pslverr_out = st_q.pslverr;
	assign lock_irq_out = st_q.irq;
	assign loop_enable_out = st_q.loop_en;
	assign tracking_mode_out = st_q.tracking;
	assign feedback_mult_out = st_q.fb_mult;
	assign range_mult_out = st_q.rng_mult;
endmodule

// ### design/tolerance_window_latch.sv
// Hysteresis latch: sets inside the inner tolerance, clears outside the outer
`timescale 1ns/100ps
module tolerance_window_latch (
	input wire logic ref_clk_in, // System clock
	input wire logic rst_b_in, // Asynchronous reset, active low
	input wire logic enable_in, // Detector active
	input wire clk_ctl_pkg::tol_win_t window_in, // Inner and outer tolerance hits
	output logic held_out // Latched in-tolerance indication
);
	import clk_ctl_pkg::*;

	win_st_t st_q;
	win_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (!enable_in) begin
			st_d.held = 1'b0;
		end else if (window_in.inner) begin
			st_d.held = 1'b1;
		end else if (!window_in.outer) begin
			st_d.held = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign held_out = st_q.held;
endmodule

// ### dv/bus_clock_sink.sv
// Clock consumer model: halves the base clock and measures its period
`timescale 1ns/100ps
module bus_clock_sink (
	input wire logic ref_clk_in, // System clock
	input wire logic rst_b_in, // Reset, active low
	input wire logic base_clock_in, // Base clock
	output logic bus_clock_out, // Base clock halved
	output logic [7:0] period_out // Cycles between base rises
);
	logic prev_q;
	logic [7:0] cnt_q;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prev_q <= 1'b0;
			cnt_q <= 8'h00;
			period_out <= 8'h00;
			bus_clock_out <= 1'b0;
		end else begin
			prev_q <= base_clock_in;
			cnt_q <= cnt_q + 8'h01;
			if (base_clock_in && !prev_q) begin
				period_out <= cnt_q + 8'h01;
				cnt_q <= 8'h00;
				bus_clock_out <= !bus_clock_out;
			end
		end
	end
endmodule

// ### dv/pll_mode_and_base_clock_select_props.sv
// Port-level checks on the loop mode and base clock control block
`timescale 1ns/100ps
module pll_mode_and_base_clock_select_props
	import clk_ctl_pkg::*;
(
	input wire logic ref_clk_in, // Clock
	input wire logic rst_b_in, // Reset
	input wire logic psel_in, // Select
	input wire logic penable_in, // Enable
	input wire logic pwrite_in, // Write
	input wire logic [9:0] paddr_in, // Address
	input wire logic pready_out, // Ready
	input wire logic pslverr_out, // Error
	input wire logic base_clock_out, // Base clock
	input wire logic lock_irq_out, // Interrupt
	input wire logic loop_enable_out, // Loop live
	input wire logic [3:0] feedback_mult_out, // N
	input wire logic [3:0] range_mult_out // L
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// ==============================
	// Bus phases
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_prog_wr;
		psel_in && penable_in && pready_out ##0 pwrite_in && paddr_in == MULT_PROG_ADDR;
	endsequence
	property p_ready;
		s_setup |=> pready_out;
	endproperty
	property p_err;
		pslverr_out |-> pready_out && $past(psel_in && !penable_in);
	endproperty
	property p_fb;
		feedback_mult_out != 4'h0;
	endproperty
	property p_rng;
		range_mult_out == 4'h0 |-> !loop_enable_out;
	endproperty
	// Loop live implies loop on, so the whole register must hold
	property p_prog;
		s_prog_wr ##0 loop_enable_out |=> ($stable(feedback_mult_out) && $stable(range_mult_out))[*2];
	endproperty
	// Source edges are at least four cycles apart, so halved output is too
	property p_div;
		$changed(base_clock_out) |=> $stable(base_clock_out)[*3];
	endproperty
	property p_irq_fall;
		$fell(lock_irq_out) |-> $past(psel_in && penable_in) || $past(psel_in && penable_in, 2);
	endproperty
	property p_loop_fall;
		$fell(loop_enable_out) |-> $past(psel_in && pwrite_in) || $past(psel_in && pwrite_in, 2);
	endproperty
	a_ready: assert property (p_ready) else $error("ready missing after setup");
	a_err: assert property (p_err) else $error("error outside access");
	a_fb: assert property (p_fb) else $error("feedback multiplier zero");
	a_rng: assert property (p_rng) else $error("loop live with range zero");
	a_prog: assert property (p_prog) else $error("multiplier changed while on");
	a_div: assert property (p_div) else $error("base clock too fast");
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
	a_loop_fall: assert property (p_loop_fall) else $error("loop dropped by itself");
endmodule

bind pll_mode_and_base_clock_select pll_mode_and_base_clock_select_props
	pll_mode_and_base_clock_select_props_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .base_clock_out(base_clock_out),
	.lock_irq_out(lock_irq_out), .loop_enable_out(loop_enable_out),
	.feedback_mult_out(feedback_mult_out), .range_mult_out(range_mult_out));

// ### dv/test_pll_mode_and_base_clock_select.sv
// Self-checking bench for loop mode control and base clock selection
`timescale 1ns/100ps
module test_pll_mode_and_base_clock_select;
	import clk_ctl_pkg::*;
	logic ref_clk_in, rst_b_in, psel, pen, pwr, xt, vc, prdy, perr, bclk, irq, len, trk, er;
	logic [9:0] pa;
	logic [31:0] pwd, prd, rd;
	logic [3:0] fb, rng;
	logic [7:0] per;
	tol_win_t tw, lw;
	int cyc, n_fail, samples_checked;
	pll_mode_and_base_clock_select pll_mode_and_base_clock_select_i (.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .crystal_clock_in(xt), .vco_clock_in(vc),
		.track_window_in(tw), .lock_window_in(lw), .base_clock_out(bclk),
		.lock_irq_out(irq), .loop_enable_out(len), .tracking_mode_out(trk),
		.feedback_mult_out(fb), .range_mult_out(rng));
	bus_clock_sink bus_clock_sink_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.base_clock_in(bclk), .bus_clock_out(), .period_out(per));
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// Crystal period 4 cycles, VCO period 6 cycles
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		xt <= (cyc % 4) > 1;
		vc <= (cyc % 6) > 2;
	end
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Holds the request until ready is sampled, then leaves time for outputs to settle
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge ref_clk_in);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= a;
		pwd <= {24'h000000, d};
		@(posedge ref_clk_in);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (prdy !== 1'b1 && n < 16);
		if (prdy !== 1'b1) begin
			n_fail++;
			print_verdict();
		end
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), {24'h000000, exp}, rd);
	endtask
	task automatic t_reset();
		chk("feedback", 1, fb);
		chk("range", 1, rng);
		chk("loop", 1, len);
		rdchk(LOOP_CTRL_ADDR, 8'h2f);
		rdchk(BW_CTRL_ADDR, 8'h00);
		rdchk(MULT_PROG_ADDR, 8'h11);
		apb(1'b0, 10'h3fc, 8'h00);
		chk("unmapped", 1, er);
	endtask
	task automatic t_prog();
		apb(1'b1, MULT_PROG_ADDR, 8'h53);
		rdchk(MULT_PROG_ADDR, 8'h11);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h00);
		apb(1'b1, MULT_PROG_ADDR, 8'h03);
		chk("feedback", 1, fb);
		chk("range", 3, rng);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h10);
		rdchk(LOOP_CTRL_ADDR, 8'h0f);
		apb(1'b1, MULT_PROG_ADDR, 8'h50);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h20);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h30);
		chk("loop", 0, len);
		rdchk(LOOP_CTRL_ADDR, 8'h2f);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h00);
		apb(1'b1, MULT_PROG_ADDR, 8'h21);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h30);
		rdchk(LOOP_CTRL_ADDR, 8'h2f);
		chk("feedback", 2, fb);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h30);
		rdchk(LOOP_CTRL_ADDR, 8'h3f);
		repeat (60) @(posedge ref_clk_in);
		chk("vco period", 12, per);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h00);
		rdchk(LOOP_CTRL_ADDR, 8'h2f);
		repeat (60) @(posedge ref_clk_in);
		chk("xtal period", 8, per);
	endtask
	task automatic t_manual();
		lw <= 2'b11;
		apb(1'b1, LOOP_CTRL_ADDR, 8'h00);
		apb(1'b1, BW_CTRL_ADDR, 8'h00);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h20);
		repeat (20) @(posedge ref_clk_in);
		apb(1'b1, BW_CTRL_ADDR, 8'h20);
		chk("tracking", 1, trk);
		repeat (20) @(posedge ref_clk_in);
		apb(1'b1, LOOP_CTRL_ADDR, 8'hb0);
		rdchk(LOOP_CTRL_ADDR, 8'h3f);
		rdchk(BW_CTRL_ADDR, 8'h20);
		chk("irq", 0, irq);
		apb(1'b1, LOOP_CTRL_ADDR, 8'h20);
		apb(1'b1, BW_CTRL_ADDR, 8'h00);
		chk("tracking", 0, trk);
	endtask
	task automatic t_auto();
		apb(1'b1, BW_CTRL_ADDR, 8'h80);
		apb(1'b1, LOOP_CTRL_ADDR, 8'ha0);
		rdchk(BW_CTRL_ADDR, 8'hc0);
		chk("irq", 1, irq);
		apb(1'b1, LOOP_CTRL_ADDR, 8'hb0);
		rdchk(LOOP_CTRL_ADDR, 8'hff);
		chk("irq", 0, irq);
		tw <= 2'b11;
		apb(1'b1, BW_CTRL_ADDR, 8'h80);
		rdchk(BW_CTRL_ADDR, 8'he0);
		chk("tracking", 1, trk);
		tw <= 2'b01;
		lw <= 2'b01;
		rdchk(BW_CTRL_ADDR, 8'he0);
		tw <= 2'b00;
		lw <= 2'b00;
		rdchk(BW_CTRL_ADDR, 8'h80);
		apb(1'b1, LOOP_CTRL_ADDR, 8'ha0);
		chk("irq", 1, irq);
		apb(1'b1, BW_CTRL_ADDR, 8'h00);
		chk("irq", 0, irq);
		rdchk(LOOP_CTRL_ADDR, 8'h2f);
	endtask
	initial begin
		rst_b_in = 1'b0;
		{psel, pen, pwr, xt, vc} = 5'h00;
		pa = 10'h000;
		pwd = 32'h00000000;
		tw = 2'b00;
		lw = 2'b00;
		cyc = 0;
		n_fail = 0;
		samples_checked = 0;
		repeat (10) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_prog();
		t_manual();
		t_auto();
		print_verdict();
	end
endmodule
